/* common/mmd_pkg.sv */
// Package with address windows, select bit positions and target codes of the map decoder.
package mmd_pkg;
	// Route targets of one CPU access.
	typedef enum logic [3:0] {
		MMD_TGT_EXT = 4'h0,
		MMD_TGT_FLASH = 4'h1,
		MMD_TGT_SRAM = 4'h2,
		MMD_TGT_LRAM = 4'h3,
		MMD_TGT_CAN1 = 4'h4,
		MMD_TGT_CAN2 = 4'h5,
		MMD_TGT_RTC = 4'h6,
		MMD_TGT_PWM = 4'h7,
		MMD_TGT_ASC = 4'h8,
		MMD_TGT_SSC = 4'h9,
		MMD_TGT_I2C = 4'hA,
		MMD_TGT_MISC = 4'hB
	} mmd_tgt_type;
	// Access sequencer states, Gray coded along idle, wait, done.
	typedef enum logic [1:0] {
		MMD_ST_IDLE = 2'h0,
		MMD_ST_WAIT = 2'h1,
		MMD_ST_DONE = 2'h3
	} mmd_state_type;
	// Bit positions in the system and peripheral select registers.
	localparam int MMD_GLOBAL_EN_BIT = 2;
	localparam int MMD_SEL_CAN1 = 0;
	localparam int MMD_SEL_CAN2 = 1;
	localparam int MMD_SEL_SRAM = 2;
	localparam int MMD_SEL_LRAM = 3;
	// Window bounds.
	localparam logic [23:0] MMD_SRAM_FIRST = 24'h00E000;
	localparam logic [23:0] MMD_SRAM_LAST = 24'h00E7FF;
	localparam logic [23:0] MMD_LRAM_FIRST = 24'h0F0000;
	localparam logic [23:0] MMD_LRAM_LAST = 24'h0F7FFF;
	localparam logic [23:0] MMD_PERI_FIRST = 24'h00E800;
	localparam logic [23:0] MMD_PERI_LAST = 24'h00EFFF;
	localparam logic [23:0] MMD_FL_LOW_LAST = 24'h007FFF;
	localparam logic [23:0] MMD_FL_TEST_LAST = 24'h001FFF;
	localparam logic [23:0] MMD_FL_S4_FIRST = 24'h018000;
	localparam logic [23:0] MMD_FL_LAST = 24'h08FFFF;
	// Sector codes; bank one holds the last two sectors.
	localparam logic [3:0] MMD_SECT_FOUR = 4'h4;
	localparam logic [3:0] MMD_SECT_BANK1 = 4'hA;
	localparam logic [3:0] MMD_SECT_TEST = 4'hD;
	// Peripheral pages E8..EF: select bit and target of each page.
	localparam logic [3:0] MMD_PAGE_SEL [8] = '{4'h8, 4'h7, 4'h9, 4'hA, 4'h6, 4'h4, 4'h1, 4'h0};
	localparam mmd_tgt_type MMD_PAGE_TGT [8] = '{MMD_TGT_SSC, MMD_TGT_ASC, MMD_TGT_I2C,
		MMD_TGT_MISC, MMD_TGT_PWM, MMD_TGT_RTC, MMD_TGT_CAN2, MMD_TGT_CAN1};
	// Wait states and segment address line counts.
	localparam logic [1:0] MMD_WAIT_PERI = 2'h2;
	localparam logic [1:0] MMD_WAIT_RAM = 2'h0;
	localparam logic [3:0] MMD_SEG_LINES_FULL = 4'h8;
	localparam logic [3:0] MMD_SEG_LINES_CAN = 4'h4;
endpackage

/* common/mmd_flash_if.sv */
// Interface carrying an address to the flash sector map and its answer back.
`timescale 1ns/1ps
interface mmd_flash_if;
	logic [23:0] addr;
	logic boot;
	logic hit;
	logic [3:0] sector;
	logic bank;
	modport map (input addr, input boot, output hit, output sector, output bank);
	modport user (output addr, output boot, input hit, input sector, input bank);
endinterface

/* hw/mmd_flash_map.sv */
// Combinational flash sector map for user and bootstrap modes.
`timescale 1ns/1ps
module mmd_flash_map
	import mmd_pkg::*;
(
	mmd_flash_if.map fl
);
	// Low sectors are 8K each, sector four is 32K, the rest are 64K per segment.
	always_comb begin
		fl.hit = 1'b0;
		fl.sector = 4'h0;
		if (fl.boot && fl.addr <= MMD_FL_TEST_LAST) begin
			fl.hit = 1'b1;
			fl.sector = MMD_SECT_TEST;
		end else if (fl.addr <= MMD_FL_LOW_LAST) begin
			fl.hit = 1'b1;
			fl.sector = {2'h0, fl.addr[14:13]};
		end else if (fl.addr >= MMD_FL_S4_FIRST && fl.addr <= MMD_FL_LAST) begin
			fl.hit = 1'b1;
			fl.sector = (fl.addr[19:16] == 4'h1) ? MMD_SECT_FOUR : 4'(fl.addr[19:16] + 4'h3);
		end
		fl.bank = (fl.sector >= MMD_SECT_BANK1) && (fl.sector != MMD_SECT_TEST);
	end
endmodule // mmd_flash_map

/* hw/mmd_top.sv */
// Address decoder routing CPU accesses to flash, extension RAM, bus peripherals or external bus.
`timescale 1ns/1ps
module mmd_top
	import mmd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [15:0] system_config_reg,
	input wire logic [15:0] periph_select_reg,
	input wire logic boot_pin,
	input wire logic [1:0] bank_modify,
	input wire logic req_valid,
	input wire logic [23:0] req_addr,
	input wire logic req_write,
	input wire logic req_byte,
	input wire logic req_stack,
	input wire logic req_bitop,
	output logic busy_ff,
	output logic ack_ff,
	output logic fault_ff,
	output mmd_tgt_type target_ff,
	output logic [1:0] wait_states_ff,
	output logic [3:0] sector_ff,
	output logic ext_req_ff,
	output logic [23:0] ext_addr_ff,
	output logic ext_write_ff,
	output logic ext_byte_ff,
	output logic [3:0] seg_lines_ff,
	output logic [10:0] periph_claim_ff,
	output logic boot_mode_ff
);
	mmd_flash_if fl ();
	mmd_state_type state_ff;
	mmd_state_type nxt_state;
	logic [1:0] wait_cnt_ff;
	logic boot_s1_ff;
	logic boot_s2_ff;
	logic boot_s3_ff;
	logic global_en;
	logic [7:0] page_hit;
	mmd_tgt_type nxt_target;
	logic [1:0] nxt_waits;
	logic nxt_word_only;
	logic nxt_is_ram;
	logic nxt_fault;
	logic take;

	// True when the address falls inside the closed window first..last.
	function automatic logic in_win(input logic [23:0] a, input logic [23:0] first,
		input logic [23:0] last);
		in_win = (a >= first) && (a <= last);
	endfunction

	assign global_en = system_config_reg[MMD_GLOBAL_EN_BIT];
	assign take = req_valid && (state_ff == MMD_ST_IDLE);
	assign fl.addr = req_addr;
	assign fl.boot = boot_mode_ff;

	mmd_flash_map u_flash_map (
		.fl(fl)
	);

	// The boot strap is a pin; the first stage feeds only the second stage.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			boot_s1_ff <= 1'b0;
			boot_s2_ff <= 1'b0;
			boot_s3_ff <= 1'b0;
		end else begin
			boot_s1_ff <= boot_pin;
			boot_s2_ff <= boot_s1_ff;
			boot_s3_ff <= boot_s2_ff;
		end
	end

	// The mode changes only once two stages agree, filtering a single-cycle glitch.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			boot_mode_ff <= 1'b0;
		end else if (boot_s2_ff == boot_s3_ff) begin
			boot_mode_ff <= boot_s3_ff;
		end
	end

	// One hit per 256-byte peripheral page, each gated by its own select bit.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_page
			assign page_hit[gi] = global_en && periph_select_reg[MMD_PAGE_SEL[gi]] &&
				in_win(req_addr, MMD_PERI_FIRST, MMD_PERI_LAST) &&
				(req_addr[10:8] == 3'(gi));
		end
	endgenerate

	// Decode priority: on-chip RAM, peripherals, flash; everything else goes out.
	always_comb begin
		nxt_target = MMD_TGT_EXT;
		nxt_waits = MMD_WAIT_RAM;
		nxt_word_only = 1'b0;
		nxt_is_ram = 1'b0;
		if (global_en && periph_select_reg[MMD_SEL_SRAM] &&
			in_win(req_addr, MMD_SRAM_FIRST, MMD_SRAM_LAST)) begin
			nxt_target = MMD_TGT_SRAM;
			nxt_is_ram = 1'b1;
		end else if (global_en && periph_select_reg[MMD_SEL_LRAM] &&
			in_win(req_addr, MMD_LRAM_FIRST, MMD_LRAM_LAST)) begin
			nxt_target = MMD_TGT_LRAM;
			nxt_is_ram = 1'b1;
		end else if (|page_hit) begin
			for (int i = 0; i < 8; i++) begin
				if (page_hit[i]) begin
					nxt_target = MMD_PAGE_TGT[i];
				end
			end
			nxt_waits = MMD_WAIT_PERI;
			nxt_word_only = 1'b1;
		end else if (fl.hit) begin
			nxt_target = MMD_TGT_FLASH;
		end
	end

	// Faults: byte to a word-only window, stack or bit use of extension RAM, busy bank read.
	always_comb begin
		nxt_fault = 1'b0;
		if (nxt_word_only && req_byte) begin
			nxt_fault = 1'b1;
		end else if (nxt_is_ram && (req_stack || req_bitop)) begin
			nxt_fault = 1'b1;
		end else if (nxt_target == MMD_TGT_FLASH && !req_write && bank_modify[fl.bank]) begin
			nxt_fault = 1'b1;
		end
	end

	// Sequencer: zero-wait and faulted accesses answer after one cycle, other peripheral accesses after the wait states.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			MMD_ST_IDLE: begin
				if (take) begin
					nxt_state = (nxt_waits != 2'h0 && !nxt_fault) ? MMD_ST_WAIT : MMD_ST_DONE;
				end
			end
			MMD_ST_WAIT: begin
				if (wait_cnt_ff == 2'h1) begin
					nxt_state = MMD_ST_DONE;
				end
			end
			MMD_ST_DONE: begin
				nxt_state = MMD_ST_IDLE;
			end
			default: begin
				nxt_state = MMD_ST_IDLE;
			end
		endcase
	end

	// State register and the answer strobe, which marks the done cycle.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= MMD_ST_IDLE;
			ack_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			ack_ff <= (nxt_state == MMD_ST_DONE);
			busy_ff <= (nxt_state != MMD_ST_IDLE);
		end
	end

	// Wait-state counter; a faulted access skips its waits.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt_ff <= 2'h0;
		end else if (take) begin
			wait_cnt_ff <= nxt_waits;
		end else if (state_ff == MMD_ST_WAIT) begin
			wait_cnt_ff <= wait_cnt_ff - 2'h1;
		end
	end

	// Route result, held until the next accepted request.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			target_ff <= MMD_TGT_EXT;
			wait_states_ff <= 2'h0;
			sector_ff <= 4'h0;
			fault_ff <= 1'b0;
		end else if (take) begin
			target_ff <= nxt_target;
			wait_states_ff <= nxt_waits;
			sector_ff <= fl.hit ? fl.sector : 4'h0;
			fault_ff <= nxt_fault;
		end
	end

	// External forward: one-cycle strobe, address passed through unchanged.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ext_req_ff <= 1'b0;
			ext_addr_ff <= 24'h000000;
			ext_write_ff <= 1'b0;
			ext_byte_ff <= 1'b0;
		end else begin
			ext_req_ff <= take && (nxt_target == MMD_TGT_EXT);
			if (take && nxt_target == MMD_TGT_EXT) begin
				ext_addr_ff <= req_addr;
				ext_write_ff <= req_write;
				ext_byte_ff <= req_byte;
			end
		end
	end

	// Ownership of peripheral pins and interrupts, and the segment line count.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			periph_claim_ff <= 11'h000;
			seg_lines_ff <= MMD_SEG_LINES_FULL;
		end else begin
			periph_claim_ff <= global_en ? periph_select_reg[10:0] : 11'h000;
			if (global_en && (periph_select_reg[MMD_SEL_CAN1] ||
				periph_select_reg[MMD_SEL_CAN2])) begin
				seg_lines_ff <= MMD_SEG_LINES_CAN;
			end else begin
				seg_lines_ff <= MMD_SEG_LINES_FULL;
			end
		end
	end

	// Checks on the design's own outputs.
	zero_wait_ack_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && nxt_waits == 2'h0 |=> ack_ff)
		else $error("Zero-wait access not answered next cycle.");
	peri_wait_ack_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && nxt_waits == MMD_WAIT_PERI && !nxt_fault |=> !ack_ff [*2] ##1 ack_ff)
		else $error("Peripheral access not answered after two wait states.");
	sram_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take ##1 target_ff == MMD_TGT_SRAM |-> $past(global_en) &&
		$past(periph_select_reg[MMD_SEL_SRAM]))
		else $error("Small RAM decoded without both enables.");
	sram_fallback_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && in_win(req_addr, MMD_SRAM_FIRST, MMD_SRAM_LAST) &&
		!(global_en && periph_select_reg[MMD_SEL_SRAM]) |=> ext_req_ff && ack_ff)
		else $error("Disabled small RAM range not forwarded.");
	lram_fallback_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && in_win(req_addr, MMD_LRAM_FIRST, MMD_LRAM_LAST) && !global_en
		|=> ext_req_ff && ext_addr_ff == $past(req_addr))
		else $error("Large RAM range not forwarded with global enable clear.");
	can1_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && req_addr[23:8] == 16'h00EF && global_en && periph_select_reg[MMD_SEL_CAN1]
		|=> target_ff == MMD_TGT_CAN1)
		else $error("First CAN window not routed.");
	byte_fault_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && nxt_word_only && req_byte |=> fault_ff && ack_ff)
		else $error("Byte access to word-only window not faulted.");
	ram_stack_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && nxt_is_ram && req_stack |=> fault_ff)
		else $error("Stack use of extension RAM not faulted.");
	seg_lines_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		global_en && periph_select_reg[MMD_SEL_CAN2] |=> seg_lines_ff == MMD_SEG_LINES_CAN)
		else $error("Segment lines not limited with CAN in use.");
	claim_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!global_en |=> periph_claim_ff == 11'h000)
		else $error("Peripheral claims resources while bus disabled.");
	test_sector_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && req_addr == 24'h000000 |=> sector_ff == ($past(boot_mode_ff) ?
		MMD_SECT_TEST : 4'h0))
		else $error("Address zero maps the wrong sector for the mode.");
	sector_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && in_win(req_addr, 24'h008000, 24'h017FFF) |=> target_ff != MMD_TGT_FLASH)
		else $error("Gap below sector four decoded as flash.");
	busy_bank_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && fl.hit && !req_write && bank_modify[fl.bank] |=> fault_ff)
		else $error("Read of a bank under modification not faulted.");
	lram_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && global_en && periph_select_reg[MMD_SEL_LRAM] &&
		in_win(req_addr, MMD_LRAM_FIRST, MMD_LRAM_LAST) |=> target_ff == MMD_TGT_LRAM)
		else $error("Large RAM window not routed with both enables set.");
	can2_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && req_addr[23:8] == 16'h00EE && global_en && periph_select_reg[MMD_SEL_CAN2]
		|=> target_ff == MMD_TGT_CAN2)
		else $error("Second CAN window not routed.");
	ext_pass_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && !fl.hit && !in_win(req_addr, MMD_SRAM_FIRST, MMD_PERI_LAST) &&
		!in_win(req_addr, MMD_LRAM_FIRST, MMD_LRAM_LAST)
		|=> ext_req_ff && ext_addr_ff == $past(req_addr) && !fault_ff)
		else $error("Unmatched address not forwarded unchanged.");
	ram_byte_ok_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && nxt_is_ram && !req_stack && !req_bitop |=> !fault_ff && ack_ff)
		else $error("Plain extension RAM access faulted or delayed.");
	sector_four_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && in_win(req_addr, MMD_FL_S4_FIRST, 24'h01FFFF)
		|=> target_ff == MMD_TGT_FLASH && sector_ff == MMD_SECT_FOUR)
		else $error("Sector four window not mapped.");
	ext_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ext_req_ff |=> !ext_req_ff)
		else $error("External forward strobe held longer than one cycle.");
	claim_on_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		global_en |=> periph_claim_ff == $past(periph_select_reg[10:0]))
		else $error("Peripheral claims do not follow the select bits.");
	lram_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		take && global_en && !periph_select_reg[MMD_SEL_LRAM] &&
		in_win(req_addr, MMD_LRAM_FIRST, MMD_LRAM_LAST) |=> ext_req_ff)
		else $error("Deselected large RAM range not forwarded.");

	// Page routing stated from the same MMD_PAGE_SEL and MMD_PAGE_TGT tables as the decoder, so a swapped table does not show.
	property page_route_p(int pg);
		@(posedge clk_sys) disable iff (!rst_n)
		take && global_en && periph_select_reg[MMD_PAGE_SEL[pg]] &&
		req_addr[23:8] == 16'(16'h00E8 + pg) |=> target_ff == MMD_PAGE_TGT[pg];
	endproperty
	generate
		for (gi = 0; gi < 8; gi++) begin : g_page_chk
			page_route_a: assert property (page_route_p(gi))
				else $error("Enabled peripheral page routed to the wrong target.");
		end
	endgenerate

	// Main scenarios.
	cov_ext_c: cover property (@(posedge clk_sys) disable iff (!rst_n) ext_req_ff);
	cov_fault_c: cover property (@(posedge clk_sys) disable iff (!rst_n) ack_ff && fault_ff);
	cov_peri_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		state_ff == MMD_ST_WAIT ##2 ack_ff);
	cov_lram_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		ack_ff && target_ff == MMD_TGT_LRAM);
	cov_boot_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		ack_ff && sector_ff == MMD_SECT_TEST);
endmodule // mmd_top

/* verification/mmd_cpu_model.sv */
// Behavioural CPU core that issues one access at a time to the map decoder.
`timescale 1ns/1ps
module mmd_cpu_model (
	input wire logic clk_sys,
	input wire logic ack_ff,
	input wire logic ext_req_ff,
	output logic req_valid,
	output logic [23:0] req_addr,
	output logic req_write,
	output logic req_byte,
	output logic req_stack,
	output logic req_bitop
);
	// Lines start idle; the address is inverted after each access so a stale value never matches.
	initial begin
		req_valid = 1'b0;
		req_addr = 24'h000000;
		{req_write, req_byte, req_stack, req_bitop} = 4'h0;
	end

	// Holds the request until the edge that samples the answer, then releases it.
	// The kind bits are write, byte, stack and bit access; stack, bit and busy-bank reads
	// are only issued when a scenario asks for them.
	task automatic access(input logic [23:0] a, input logic [3:0] k, output int lat,
		output logic ext);
		lat = 0;
		ext = 1'b0;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_addr <= a;
		{req_write, req_byte, req_stack, req_bitop} <= k;
		while (lat < 16) begin
			@(posedge clk_sys);
			lat++;
			if (ack_ff === 1'b1) begin
				ext = ext_req_ff;
				break;
			end
		end
		req_valid <= 1'b0;
		req_addr <= ~a;
	endtask
endmodule // mmd_cpu_model

/* verification/testbench.sv */
// Self-checking testbench for the memory map decoder.
`timescale 1ns/1ps
module testbench
	import mmd_pkg::*;
;
	logic clk_sys, rst_n, boot_pin, req_valid, req_write, req_byte, req_stack, req_bitop;
	logic busy_ff, ack_ff, fault_ff, ext_req_ff, ext_write_ff, ext_byte_ff, boot_mode_ff;
	logic [15:0] system_config_reg, periph_select_reg;
	logic [1:0] bank_modify, wait_states_ff;
	logic [23:0] req_addr, ext_addr_ff;
	logic [3:0] sector_ff, seg_lines_ff;
	logic [10:0] periph_claim_ff;
	mmd_tgt_type target_ff;
	int err_total = 0;
	int n_tests = 0;
	int cycles = 0;
	int lat;
	logic ext;

	mmd_top u_dut (.clk_sys, .rst_n, .system_config_reg, .periph_select_reg, .boot_pin,
		.bank_modify, .req_valid, .req_addr, .req_write, .req_byte, .req_stack, .req_bitop,
		.busy_ff, .ack_ff, .fault_ff, .target_ff, .wait_states_ff, .sector_ff, .ext_req_ff,
		.ext_addr_ff, .ext_write_ff, .ext_byte_ff, .seg_lines_ff, .periph_claim_ff,
		.boot_mode_ff);
	mmd_cpu_model u_cpu (.clk_sys, .ack_ff, .ext_req_ff, .req_valid, .req_addr, .req_write,
		.req_byte, .req_stack, .req_bitop);

	// Free-running 50 MHz system clock.
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
			err_total++;
		end
	endtask

	// One access and all its answers; peripherals that are not faulted take two wait states.
	task automatic rt(input logic [23:0] a, input logic [3:0] k, input mmd_tgt_type tg,
		input logic flt, input logic [3:0] sec);
		logic peri;
		logic fwd;
		peri = (tg >= MMD_TGT_CAN1) && !flt;
		fwd = (tg == MMD_TGT_EXT) && !flt;
		u_cpu.access(a, k, lat, ext);
		#1;
		chk("target", 24'(tg), 24'(target_ff));
		chk("fault", 24'(flt), 24'(fault_ff));
		chk("latency", peri ? 24'h4 : 24'h2, 24'(lat));
		// A faulted peripheral access still records the window's two wait states.
		chk("wait states", (tg >= MMD_TGT_CAN1) ? 24'h2 : 24'h0, 24'(wait_states_ff));
		chk("busy", 24'h0, 24'(busy_ff));
		chk("sector", 24'(sec), 24'(sector_ff));
		chk("forward", 24'(fwd), 24'(ext));
		if (fwd) begin
			chk("ext address", a, ext_addr_ff);
			chk("ext kind", 24'(k[3:2]), 24'({ext_write_ff, ext_byte_ff}));
		end
	endtask

	// Configuration changes land on an edge; the decoder follows one cycle later.
	task automatic cfg(input logic g, input logic [15:0] sel);
		@(posedge clk_sys);
		system_config_reg <= {13'h0000, g, 2'h0};
		periph_select_reg <= sel;
		@(posedge clk_sys);
		#1;
	endtask

	task automatic t_ram();
		cfg(1'b1, 16'h000C);
		rt(24'h00E000, 4'h0, MMD_TGT_SRAM, 1'b0, 4'h0);
		rt(24'h00E7FF, 4'hC, MMD_TGT_SRAM, 1'b0, 4'h0);
		rt(24'h0F0000, 4'h4, MMD_TGT_LRAM, 1'b0, 4'h0);
		rt(24'h0F7FFE, 4'h8, MMD_TGT_LRAM, 1'b0, 4'h0);
		rt(24'h00E010, 4'h2, MMD_TGT_SRAM, 1'b1, 4'h0);
		rt(24'h0F0010, 4'h1, MMD_TGT_LRAM, 1'b1, 4'h0);
		cfg(1'b1, 16'h0008);
		rt(24'h00E7FE, 4'hC, MMD_TGT_EXT, 1'b0, 4'h0);
		cfg(1'b0, 16'h000C);
		rt(24'h00E000, 4'h0, MMD_TGT_EXT, 1'b0, 4'h0);
		rt(24'h0F1234, 4'h4, MMD_TGT_EXT, 1'b0, 4'h0);
		$display("test ram done");
	endtask

	// Each page E8..EF alone selected, then alone deselected, then globally disabled.
	task automatic t_peri();
		int sb[8] = '{8, 7, 9, 10, 6, 4, 1, 0};
		mmd_tgt_type tt[8] = '{MMD_TGT_SSC, MMD_TGT_ASC, MMD_TGT_I2C, MMD_TGT_MISC,
			MMD_TGT_PWM, MMD_TGT_RTC, MMD_TGT_CAN2, MMD_TGT_CAN1};
		logic [23:0] a;
		for (int p = 0; p < 8; p++) begin
			a = 24'h00E802 + 24'(p * 256);
			cfg(1'b1, 16'(1 << sb[p]));
			rt(a, 4'h8, tt[p], 1'b0, 4'h0);
			rt(a, 4'h4, tt[p], 1'b1, 4'h0);
			chk("claim", 24'(1 << sb[p]), 24'(periph_claim_ff));
			chk("seg lines", (sb[p] < 2) ? 24'h4 : 24'h8, 24'(seg_lines_ff));
			cfg(1'b1, 16'h07FF ^ 16'(1 << sb[p]));
			rt(a, 4'h0, MMD_TGT_EXT, 1'b0, 4'h0);
			cfg(1'b0, 16'h07FF);
			rt(a, 4'h8, MMD_TGT_EXT, 1'b0, 4'h0);
			chk("claim", 24'h0, 24'(periph_claim_ff));
			chk("seg lines", 24'h8, 24'(seg_lines_ff));
		end
		$display("test peripherals done");
	endtask

	task automatic t_flash();
		cfg(1'b1, 16'h0000);
		rt(24'h000000, 4'h0, MMD_TGT_FLASH, 1'b0, 4'h0);
		rt(24'h007FFF, 4'h4, MMD_TGT_FLASH, 1'b0, 4'h3);
		rt(24'h008000, 4'h0, MMD_TGT_EXT, 1'b0, 4'h0);
		rt(24'h017FFE, 4'h0, MMD_TGT_EXT, 1'b0, 4'h0);
		rt(24'h018000, 4'h0, MMD_TGT_FLASH, 1'b0, 4'h4);
		rt(24'h01FFFF, 4'h4, MMD_TGT_FLASH, 1'b0, 4'h4);
		rt(24'h020000, 4'h0, MMD_TGT_FLASH, 1'b0, 4'h5);
		rt(24'h06FFFE, 4'h0, MMD_TGT_FLASH, 1'b0, 4'h9);
		rt(24'h070000, 4'h0, MMD_TGT_FLASH, 1'b0, 4'hA);
		rt(24'h08FFFF, 4'h4, MMD_TGT_FLASH, 1'b0, 4'hB);
		rt(24'h090000, 4'h0, MMD_TGT_EXT, 1'b0, 4'h0);
		rt(24'hFFFFFF, 4'hC, MMD_TGT_EXT, 1'b0, 4'h0);
		@(posedge clk_sys);
		bank_modify <= 2'b01;
		rt(24'h002000, 4'h0, MMD_TGT_FLASH, 1'b1, 4'h1);
		rt(24'h070000, 4'h0, MMD_TGT_FLASH, 1'b0, 4'hA);
		rt(24'h002000, 4'h8, MMD_TGT_FLASH, 1'b0, 4'h1);
		@(posedge clk_sys);
		bank_modify <= 2'b10;
		rt(24'h080000, 4'h0, MMD_TGT_FLASH, 1'b1, 4'hB);
		@(posedge clk_sys);
		bank_modify <= 2'b00;
		boot_pin <= 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
		chk("boot mode", 24'h1, 24'(boot_mode_ff));
		rt(24'h000000, 4'h0, MMD_TGT_FLASH, 1'b0, 4'hD);
		rt(24'h001FFE, 4'h0, MMD_TGT_FLASH, 1'b0, 4'hD);
		rt(24'h002000, 4'h0, MMD_TGT_FLASH, 1'b0, 4'h1);
		@(posedge clk_sys);
		boot_pin <= 1'b0;
		repeat (6) @(posedge clk_sys);
		#1;
		chk("boot mode", 24'h0, 24'(boot_mode_ff));
		rt(24'h000000, 4'h0, MMD_TGT_FLASH, 1'b0, 4'h0);
		$display("test flash done");
	endtask

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// A hang ends the run well beyond the few hundred cycles the tests need.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			print_verdict();
		end
	end

	initial begin
		rst_n = 1'b0;
		boot_pin = 1'b0;
		bank_modify = 2'b00;
		system_config_reg = 16'h0000;
		periph_select_reg = 16'h0000;
		repeat (10) @(posedge clk_sys);
		#1;
		chk("reset seg lines", 24'h8, 24'(seg_lines_ff));
		chk("reset target", 24'h0, 24'(target_ff));
		chk("reset ack", 24'h0, 24'({ack_ff, busy_ff, ext_req_ff}));
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_ram();
		t_peri();
		t_flash();
		print_verdict();
	end
endmodule // testbench
